// File: hdl/rre_pkg.sv
// constants shared by the return / rotate execution block
// assumes an 8-bit core with a 12-bit data address and a 21-bit program counter
package rre_pkg;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    // opcode matching: return is 0000 0000 0001 001s, rotates are 6-bit prefixes
    localparam logic [14:0] OPC_RETURN_HI = 15'h0009;
    localparam logic [5:0] OPC_RLC = 6'h0D;
    localparam logic [5:0] OPC_RLNC = 6'h11;
    localparam int BIT_S = 0;
    localparam int BIT_D = 9;
    localparam int BIT_A = 8;
    localparam int OPC_PFX_LSB = 10;
    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    // access bank split and indexed window limit
    localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    typedef enum logic [1:0] {op_none, op_return, op_rlc, op_rlnc} rre_op_t;
    typedef enum logic [2:0] {st_idle, st_decode, st_read, st_proc, st_write} rre_state_t;
endpackage

// File: hdl/rre_addr_resolve.sv
// file-address resolution for byte-oriented operands
// assumes combinational use; inputs come from the same clock domain
`timescale 1ns/1ps
module rre_addr_resolve import rre_pkg::*; (
    input wire logic [7:0] file_addr_lit,
    input wire logic bank_bit,
    input wire logic ext_set_en,
    input wire logic [7:0] bank_select_reg,
    input wire logic [ADDR_W-1:0] index_base,
    output logic [ADDR_W-1:0] data_addr
);
    // pick indexed, access-bank or banked address
    always_comb begin
        if (bank_bit) begin
            data_addr = {bank_select_reg[ADDR_W-9:0], file_addr_lit};
        end else if (ext_set_en && (file_addr_lit <= ACCESS_LIMIT)) begin
            data_addr = index_base + {ACCESS_LO_BANK, file_addr_lit};
        end else if (file_addr_lit > ACCESS_LIMIT) begin
            data_addr = {ACCESS_HI_BANK, file_addr_lit};
        end else begin
            data_addr = {ACCESS_LO_BANK, file_addr_lit};
        end
    end
endmodule

// File: hdl/rre_exec.sv
// execution of subroutine return and the two left rotates, sequenced in four phases
// assumes all inputs come from core logic on mclk; file read data valid the cycle after rd_en
`timescale 1ns/1ps
// Overview of operation
// - the return opcode 0000 0000 0001 001s pops the stack and loads the pc from stack_top over two instruction cycles.
// - a return with s set copies shadow working, flags and bank-select into their live registers.
// - a return with s clear leaves working, status and bank-select untouched.
// - rotate through carry shifts left, bit 7 goes to carry and the old carry enters bit 0, in one cycle.
// - with d clear a rotate writes the working register and leaves the file register alone.
// - with d set a rotate writes the result back to the addressed file register.
// - with a clear the 8-bit address is taken inside the access bank.
// - with a set the bank-select register chooses the bank.
// - with a clear, extended set enabled and address at most 95, indexed literal offset is used.
// - rotate without carry moves bit 7 into bit 0 in one cycle and touches only negative and zero.
module rre_exec import rre_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic instr_start,
    input wire logic [15:0] instr_word,
    input wire logic ext_set_en,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [7:0] bank_select_reg,
    input wire logic [7:0] status_in,
    input wire logic [7:0] shadow_working,
    input wire logic [7:0] shadow_flags,
    input wire logic [7:0] shadow_bank_select,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic [7:0] file_rd_data,
    output logic busy,
    output logic [ADDR_W-1:0] file_addr,
    output logic file_rd_en,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    output logic w_wr_en,
    output logic [7:0] w_wr_data,
    output logic status_wr_en,
    output logic [7:0] status_wr_data,
    output logic bsr_wr_en,
    output logic [7:0] bsr_wr_data,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value
);
    logic rst_meta_ff, rst_sync_ff;
    rre_state_t state_ff, nxt_state;
    logic [15:0] instr_ff, nxt_instr;
    logic second_ff, nxt_second;
    logic [ADDR_W-1:0] file_addr_ff, nxt_file_addr;
    logic file_rd_en_ff, nxt_file_rd_en, file_wr_en_ff, nxt_file_wr_en;
    logic [7:0] file_wr_data_ff, nxt_file_wr_data;
    logic w_wr_en_ff, nxt_w_wr_en, status_wr_en_ff, nxt_status_wr_en;
    logic bsr_wr_en_ff, nxt_bsr_wr_en;
    logic [7:0] w_wr_data_ff, nxt_w_wr_data, status_wr_data_ff, nxt_status_wr_data;
    logic [7:0] bsr_wr_data_ff, nxt_bsr_wr_data;
    logic stack_pop_ff, nxt_stack_pop, pc_load_ff, nxt_pc_load;
    logic [PC_W-1:0] pc_value_ff, nxt_pc_value;
    logic [ADDR_W-1:0] resolved_addr;
    logic [7:0] rot_res, rot_flags;
    rre_op_t op;

    // reset release through two flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // opcode decode of the latched word
    always_comb begin
        if (instr_ff[15:1] == OPC_RETURN_HI) begin
            op = op_return;
        end else if (instr_ff[15:OPC_PFX_LSB] == OPC_RLC) begin
            op = op_rlc;
        end else if (instr_ff[15:OPC_PFX_LSB] == OPC_RLNC) begin
            op = op_rlnc;
        end else begin
            op = op_none;
        end
    end

    rre_addr_resolve u_resolve (
        .file_addr_lit(instr_ff[7:0]),
        .bank_bit(instr_ff[BIT_A]),
        .ext_set_en(ext_set_en),
        .bank_select_reg(bank_select_reg),
        .index_base(index_base),
        .data_addr(resolved_addr)
    );

    // rotate datapath and flag merge
    always_comb begin
        rot_flags = status_in;
        if (op == op_rlc) begin
            rot_res = {file_rd_data[6:0], status_in[FLAG_C]};
            rot_flags[FLAG_C] = file_rd_data[7];
        end else begin
            rot_res = {file_rd_data[6:0], file_rd_data[7]};
        end
        rot_flags[FLAG_N] = rot_res[7];
        rot_flags[FLAG_Z] = (rot_res == 8'h00);
    end

    // phase sequencer and output next values
    always_comb begin
        nxt_state = state_ff;
        nxt_instr = instr_ff;
        nxt_second = second_ff;
        nxt_file_addr = file_addr_ff;
        nxt_file_rd_en = 1'b0;
        nxt_file_wr_en = 1'b0;
        nxt_file_wr_data = file_wr_data_ff;
        nxt_w_wr_en = 1'b0;
        nxt_w_wr_data = w_wr_data_ff;
        nxt_status_wr_en = 1'b0;
        nxt_status_wr_data = status_wr_data_ff;
        nxt_bsr_wr_en = 1'b0;
        nxt_bsr_wr_data = bsr_wr_data_ff;
        nxt_stack_pop = 1'b0;
        nxt_pc_load = 1'b0;
        nxt_pc_value = pc_value_ff;
        unique case (state_ff)
            st_idle: begin
                if (instr_start) begin
                    nxt_instr = instr_word;
                    nxt_second = 1'b0;
                    nxt_state = st_decode;
                end
            end
            st_decode: begin
                nxt_state = st_read;
                if (!second_ff && (op == op_rlc || op == op_rlnc)) begin
                    nxt_file_rd_en = 1'b1;
                    nxt_file_addr = resolved_addr;
                end
            end
            st_read: begin
                nxt_state = st_proc;
            end
            st_proc: begin
                nxt_state = st_write;
                if (!second_ff && op == op_return) begin
                    nxt_stack_pop = 1'b1;
                    nxt_pc_load = 1'b1;
                    nxt_pc_value = stack_top;
                    if (instr_ff[BIT_S]) begin
                        nxt_w_wr_en = 1'b1;
                        nxt_w_wr_data = shadow_working;
                        nxt_status_wr_en = 1'b1;
                        nxt_status_wr_data = shadow_flags;
                        nxt_bsr_wr_en = 1'b1;
                        nxt_bsr_wr_data = shadow_bank_select;
                    end
                end else if (!second_ff && (op == op_rlc || op == op_rlnc)) begin
                    nxt_status_wr_en = 1'b1;
                    nxt_status_wr_data = rot_flags;
                    if (instr_ff[BIT_D]) begin
                        nxt_file_wr_en = 1'b1;
                        nxt_file_wr_data = rot_res;
                    end else begin
                        nxt_w_wr_en = 1'b1;
                        nxt_w_wr_data = rot_res;
                    end
                end
            end
            st_write: begin
                if (op == op_return && !second_ff) begin
                    nxt_second = 1'b1;
                    nxt_state = st_decode;
                end else begin
                    nxt_state = st_idle;
                end
            end
        endcase
    end

    // state and output registers
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= st_idle;
            instr_ff <= 16'h0000;
            second_ff <= 1'b0;
            file_addr_ff <= '0;
            file_rd_en_ff <= 1'b0;
            file_wr_en_ff <= 1'b0;
            file_wr_data_ff <= 8'h00;
            w_wr_en_ff <= 1'b0;
            w_wr_data_ff <= 8'h00;
            status_wr_en_ff <= 1'b0;
            status_wr_data_ff <= 8'h00;
            bsr_wr_en_ff <= 1'b0;
            bsr_wr_data_ff <= 8'h00;
            stack_pop_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_value_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            instr_ff <= nxt_instr;
            second_ff <= nxt_second;
            file_addr_ff <= nxt_file_addr;
            file_rd_en_ff <= nxt_file_rd_en;
            file_wr_en_ff <= nxt_file_wr_en;
            file_wr_data_ff <= nxt_file_wr_data;
            w_wr_en_ff <= nxt_w_wr_en;
            w_wr_data_ff <= nxt_w_wr_data;
            status_wr_en_ff <= nxt_status_wr_en;
            status_wr_data_ff <= nxt_status_wr_data;
            bsr_wr_en_ff <= nxt_bsr_wr_en;
            bsr_wr_data_ff <= nxt_bsr_wr_data;
            stack_pop_ff <= nxt_stack_pop;
            pc_load_ff <= nxt_pc_load;
            pc_value_ff <= nxt_pc_value;
        end
    end

    // port drive
    assign busy = (state_ff != st_idle);
    assign file_addr = file_addr_ff;
    assign file_rd_en = file_rd_en_ff;
    assign file_wr_en = file_wr_en_ff;
    assign file_wr_data = file_wr_data_ff;
    assign w_wr_en = w_wr_en_ff;
    assign w_wr_data = w_wr_data_ff;
    assign status_wr_en = status_wr_en_ff;
    assign status_wr_data = status_wr_data_ff;
    assign bsr_wr_en = bsr_wr_en_ff;
    assign bsr_wr_data = bsr_wr_data_ff;
    assign stack_pop = stack_pop_ff;
    assign pc_load = pc_load_ff;
    assign pc_load_value = pc_value_ff;

    // helper copies for the checks
    logic [7:0] rd_prev, st_prev;
    logic [7:0] result;
    logic ext_prev;
    always_ff @(posedge mclk) begin
        rd_prev <= file_rd_data;
        st_prev <= status_in;
        ext_prev <= ext_set_en;
    end
    assign result = file_wr_en ? file_wr_data : w_wr_data;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_ff);

    a_ret_pop_timing: assert property ((state_ff == st_idle && instr_start &&
        instr_word[15:1] == OPC_RETURN_HI) |-> ##4 (stack_pop && pc_load) ##1 busy [*4] ##1 !busy)
        else $error("return pop or length wrong");
    a_ret_shadow_copy: assert property ((pc_load && instr_ff[BIT_S]) |->
        (w_wr_en && bsr_wr_en && status_wr_en && status_wr_data == $past(shadow_flags)))
        else $error("shadow restore missing");
    a_ret_no_restore: assert property ((pc_load && !instr_ff[BIT_S]) |->
        !(w_wr_en || status_wr_en || bsr_wr_en))
        else $error("return without s changed registers");
    a_rlc_result: assert property ((op == op_rlc && (file_wr_en || w_wr_en)) |->
        (result == {rd_prev[6:0], st_prev[FLAG_C]} && status_wr_data[FLAG_C] == rd_prev[7]))
        else $error("rotate through carry wrong");
    a_dest_working: assert property ((status_wr_en && op != op_return && !instr_ff[BIT_D]) |->
        (w_wr_en && !file_wr_en))
        else $error("d clear did not target working");
    a_dest_file: assert property ((status_wr_en && op != op_return && instr_ff[BIT_D]) |->
        (file_wr_en && !w_wr_en && file_addr == $past(file_addr, 2)))
        else $error("d set did not target file");
    a_addr_access: assert property ((file_rd_en && !instr_ff[BIT_A] &&
        !(ext_prev && instr_ff[7:0] <= ACCESS_LIMIT)) |->
        file_addr == ((instr_ff[7:0] > ACCESS_LIMIT) ? {ACCESS_HI_BANK, instr_ff[7:0]} :
        {ACCESS_LO_BANK, instr_ff[7:0]}))
        else $error("access bank address wrong");
    a_addr_banked: assert property ((file_rd_en && instr_ff[BIT_A]) |->
        file_addr == {$past(bank_select_reg[ADDR_W-9:0]), instr_ff[7:0]})
        else $error("banked address wrong");
    a_addr_indexed: assert property ((file_rd_en && !instr_ff[BIT_A] && ext_prev &&
        instr_ff[7:0] <= ACCESS_LIMIT) |-> file_addr == $past(index_base) + {4'h0, instr_ff[7:0]})
        else $error("indexed address wrong");
    a_rlnc_result: assert property ((op == op_rlnc && status_wr_en) |->
        (result == {rd_prev[6:0], rd_prev[7]} && status_wr_data[FLAG_C] == st_prev[FLAG_C]))
        else $error("rotate without carry wrong");
    a_rot_flags: assert property ((status_wr_en && op != op_return) |->
        (status_wr_data[FLAG_N] == result[7] && status_wr_data[FLAG_Z] == (result == 8'h00)))
        else $error("negative or zero flag wrong");
    a_ret_quiet_second: assert property (pc_load |-> ##1
        (!(pc_load || stack_pop || w_wr_en || status_wr_en || file_wr_en || file_rd_en)) [*4])
        else $error("return second cycle not empty");

    c_ret_shadow: cover property (pc_load && instr_ff[BIT_S]);
    c_rlc_to_w: cover property (op == op_rlc && w_wr_en);
    c_rlnc_to_file: cover property (op == op_rlnc && file_wr_en);
    c_indexed: cover property (file_rd_en && !instr_ff[BIT_A] && ext_prev &&
        instr_ff[7:0] <= ACCESS_LIMIT);
endmodule

// File: testbench/test_return_rotate_exec.sv
// self-checking bench for the return / rotate execution block
// assumes rre_pkg and the design files are compiled first; one 50 MHz clock
`timescale 1ns/1ps
module test_return_rotate_exec;
    import rre_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_start = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic ext_set_en = 1'b0;
    logic [ADDR_W-1:0] index_base = 12'h200;
    logic [7:0] bank_select_reg = 8'h35;
    logic [7:0] status_in = 8'h00;
    logic [7:0] shadow_working = 8'hA5;
    logic [7:0] shadow_flags = 8'h1B;
    logic [7:0] shadow_bank_select = 8'h07;
    logic [PC_W-1:0] stack_top = 21'h12345;
    logic [7:0] file_rd_data = 8'h00;
    logic busy, file_rd_en, file_wr_en, w_wr_en, status_wr_en, bsr_wr_en, stack_pop, pc_load;
    logic [ADDR_W-1:0] file_addr;
    logic [7:0] file_wr_data, w_wr_data, status_wr_data, bsr_wr_data;
    logic [PC_W-1:0] pc_load_value;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    rre_exec dut (.mclk(mclk), .reset_n(reset_n), .instr_start(instr_start),
        .instr_word(instr_word), .ext_set_en(ext_set_en), .index_base(index_base),
        .bank_select_reg(bank_select_reg), .status_in(status_in),
        .shadow_working(shadow_working), .shadow_flags(shadow_flags),
        .shadow_bank_select(shadow_bank_select), .stack_top(stack_top),
        .file_rd_data(file_rd_data), .busy(busy), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
        .w_wr_en(w_wr_en), .w_wr_data(w_wr_data), .status_wr_en(status_wr_en),
        .status_wr_data(status_wr_data), .bsr_wr_en(bsr_wr_en), .bsr_wr_data(bsr_wr_data),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_load_value(pc_load_value));

    // free-running clock, 20 ns period
    always #10 mclk = ~mclk;

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // print the counts and the verdict, then stop
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end

    // issue one instruction and check every port against the expected walk
    task automatic run(input logic [15:0] w, input logic [7:0] f, input logic [7:0] st,
                       input logic ext);
        logic [7:0] res;
        logic [7:0] exp_st;
        logic [ADDR_W-1:0] ea;
        logic rot, rlc, ret, s, d, a;
        int n;
        ret = (w[15:1] === OPC_RETURN_HI);
        rlc = (w[15:10] === OPC_RLC);
        rot = rlc || (w[15:10] === OPC_RLNC);
        s = w[BIT_S];
        d = w[BIT_D];
        a = w[BIT_A];
        res = rlc ? {f[6:0], st[FLAG_C]} : {f[6:0], f[7]};
        exp_st = st;
        if (rlc) exp_st[FLAG_C] = f[7];
        exp_st[FLAG_Z] = (res == 8'h00);
        exp_st[FLAG_N] = res[7];
        if (a) ea = {bank_select_reg[3:0], w[7:0]};
        else if (ext && w[7:0] <= 8'h5F) ea = index_base + {4'h0, w[7:0]};
        else ea = {(w[7:0] > 8'h5F) ? 4'hF : 4'h0, w[7:0]};
        // request is taken at the next rising edge, then released
        instr_word = w;
        file_rd_data = ~f;
        status_in = st;
        ext_set_en = ext;
        instr_start = 1'b1;
        @(negedge mclk);
        instr_start = 1'b0;
        @(negedge mclk);
        // read strobe and resolved address stand in the cycle after decode
        chk("rd_en", file_rd_en, rot);
        if (rot) chk("addr", file_addr, ea);
        @(negedge mclk);
        // read data valid only in the process cycle, so an early sample sees ~f
        file_rd_data = f;
        @(negedge mclk);
        chk("file_wr_en", file_wr_en, rot && d);
        chk("w_wr_en", w_wr_en, (rot && !d) || (ret && s));
        chk("st_wr_en", status_wr_en, rot || (ret && s));
        chk("bsr_wr_en", bsr_wr_en, ret && s);
        chk("pop", {stack_pop, pc_load}, {ret, ret});
        if (rot && d) chk("file_wr_data", file_wr_data, res);
        if (rot && !d) chk("w_wr_data", w_wr_data, res);
        if (rot) chk("st_wr_data", status_wr_data, exp_st);
        if (ret) chk("pc", pc_load_value, stack_top);
        if (ret && s) chk("w_shadow", w_wr_data, shadow_working);
        if (ret && s) chk("st_shadow", status_wr_data, shadow_flags);
        if (ret && s) chk("bsr_shadow", bsr_wr_data, shadow_bank_select);
        chk("busy_q4", busy, 1'b1);
        // second return cycle does nothing but hold busy
        for (n = 0; n < (ret ? 4 : 0); n++) begin
            @(negedge mclk);
            chk("quiet", {stack_pop, pc_load, w_wr_en, status_wr_en, bsr_wr_en}, 0);
        end
        if (ret) chk("busy_ret", busy, 1'b1);
        @(negedge mclk);
        chk("busy_end", busy, 1'b0);
    endtask

    // main sequence: reset, rotates over every operand case except d clear with a set, returns, unknown opcode
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        run({OPC_RLC, 1'b1, 1'b0, 8'h20}, 8'hE6, 8'h00, 1'b0);
        run({OPC_RLC, 1'b0, 1'b0, 8'h80}, 8'h80, 8'hE8, 1'b0);
        run({OPC_RLC, 1'b1, 1'b1, 8'h10}, 8'h55, 8'h01, 1'b1);
        run({OPC_RLC, 1'b0, 1'b0, 8'h30}, 8'h7F, 8'h15, 1'b1);
        run({OPC_RLNC, 1'b1, 1'b0, 8'h5F}, 8'hAB, 8'h01, 1'b1);
        run({OPC_RLNC, 1'b0, 1'b0, 8'h60}, 8'h00, 8'h11, 1'b1);
        run({OPC_RLNC, 1'b1, 1'b1, 8'h05}, 8'h81, 8'h04, 1'b1);
        run({OPC_RLNC, 1'b0, 1'b0, 8'h5F}, 8'h40, 8'h00, 1'b0);
        run({OPC_RETURN_HI, 1'b0}, 8'h00, 8'h1F, 1'b0);
        stack_top = 21'h1ABCD;
        run({OPC_RETURN_HI, 1'b1}, 8'h00, 8'h00, 1'b1);
        run({OPC_RLC, 1'b1, 1'b0, 8'hFF}, 8'h01, 8'h01, 1'b0);
        run(16'hFFFF, 8'h00, 8'h00, 1'b0);
        summarize();
    end
endmodule
